/* File: inc/fcb_pkg.sv */
// Package with command codes, sequence offsets and timing for the flash command host
package fcb_pkg;
    // Bus widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    // Unlock addresses, word mode and byte mode
    localparam logic [23:0] UNLK1_WADDR = 24'h000555;
    localparam logic [23:0] UNLK2_WADDR = 24'h0002AA;
    localparam logic [23:0] UNLK1_BADDR = 24'h000AAA;
    localparam logic [23:0] UNLK2_BADDR = 24'h000555;
    // Command codes
    localparam logic [15:0] CMD_UNLK1   = 16'h00AA;
    localparam logic [15:0] CMD_UNLK2   = 16'h0055;
    localparam logic [15:0] CMD_EXTFN   = 16'h00EB;
    localparam logic [15:0] CMD_CRC     = 16'h0027;
    localparam logic [15:0] CMD_CONFIRM = 16'h0029;
    localparam logic [15:0] CMD_BYPASS  = 16'h0020;
    localparam logic [15:0] CMD_BYRST1  = 16'h0090;
    localparam logic [15:0] CMD_BYRST2  = 16'h0000;
    // Data counts and option words
    localparam logic [15:0] CNT_CHIP_W  = 16'h0004;
    localparam logic [15:0] CNT_CHIP_B  = 16'h0009;
    localparam logic [15:0] CNT_RANGE_W = 16'h000A;
    localparam logic [15:0] CNT_RANGE_B = 16'h0015;
    localparam logic [15:0] OPT_CHIP    = 16'hFFFF;
    localparam logic [15:0] OPT_RANGE   = 16'hFFFE;
    // Word offsets inside the sequence
    localparam logic [23:0] OFF_CRC0    = 24'h000001;
    localparam logic [23:0] OFF_START_L = 24'h000005;
    localparam logic [23:0] OFF_RSVD1   = 24'h000007;
    localparam logic [23:0] OFF_STOP_L  = 24'h000008;
    localparam logic [23:0] OFF_RSVD2   = 24'h00000A;
    // Status bit positions in the polling word
    localparam int FAIL_BIT  = 5;
    localparam int TOGL_BIT  = 6;
    // Bus cycle timing
    localparam int CLK_NS    = 20;
    localparam int TWP_NS    = 50;   // Write strobe low time
    localparam int TRD_NS    = 80;   // Read access allowance
    localparam int TWP_CYC   = (TWP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRD_CYC   = (TRD_NS + CLK_NS - 1) / CLK_NS;
    // Host operations
    typedef enum logic [1:0] {
        FCB_OP_CRC_CHIP  = 2'b00,
        FCB_OP_CRC_RANGE = 2'b01,
        FCB_OP_BYP_ENTER = 2'b10,
        FCB_OP_BYP_EXIT  = 2'b11
    } fcb_op_t;
endpackage

/* File: inc/fcb_cyc_if.sv */
// Interface between the sequencer and the flash bus cycle engine
`timescale 1ns/100ps
`default_nettype none
interface fcb_cyc_if;
    logic        req;   // Start a bus cycle
    logic        wr;    // One for write, zero for read
    logic [23:0] addr;  // Cycle address
    logic [15:0] wdata; // Write data
    logic        done;  // Cycle finished pulse
    logic [15:0] rdata; // Read data, valid with done
    modport seq (output req, wr, addr, wdata, input done, rdata);
    modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

/* File: core/fcb_cycle.sv */
// Flash bus cycle engine: one write or read cycle on the parallel pins
`timescale 1ns/100ps
`default_nettype none
module fcb_cycle (
    input  wire logic  mclk_in,     // System clock
    input  wire logic  resetn_in,   // Synchronous reset, active low
    input  wire logic  ce_in,       // Clock enable
    fcb_cyc_if.eng     cyc,         // Cycle requests
    output logic [23:0] fa_out,     // Flash address
    output logic [15:0] fdq_out,    // Flash data out
    output logic        fdq_oe_out, // Data drive enable
    input  wire logic [15:0] fdq_in,// Flash data in
    output logic        fce_n_out,  // Chip enable, low active
    output logic        fwe_n_out,  // Write enable, low active
    output logic        foe_n_out   // Output enable, low active
);
    localparam logic [3:0] WCNT = 4'(fcb_pkg::TWP_CYC);
    localparam logic [3:0] RCNT = 4'(fcb_pkg::TRD_CYC);
    logic        busy_r;            // Cycle in progress
    logic        wr_r;              // Cycle type
    logic [3:0]  cnt_r;             // Strobe timer
    logic [15:0] s1_r, s2_r;        // Read data synchroniser
    logic        done_r;            // Finish pulse
    logic [15:0] rd_r;              // Captured read data
    logic        last;              // Timer expired
    assign last = busy_r && (cnt_r == 4'h0);
    assign cyc.done  = done_r;
    assign cyc.rdata = rd_r;
    assign fce_n_out = ~busy_r;
    assign fwe_n_out = ~(busy_r && wr_r);
    assign foe_n_out = ~(busy_r && !wr_r);
    assign fdq_oe_out = busy_r && wr_r;
    // Pins sampled through two flops; timer exceeds the two-cycle lag
    always_ff @(posedge mclk_in) begin
        if (ce_in) begin
            s1_r <= fdq_in;
            s2_r <= s1_r;
        end
    end
    // Cycle timer and pin drive
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            busy_r <= 1'b0;
            wr_r <= 1'b0;
            cnt_r <= 4'h0;
            done_r <= 1'b0;
            rd_r <= 16'h0000;
            fa_out <= 24'h000000;
            fdq_out <= 16'h0000;
        end else if (ce_in) begin
            done_r <= last;
            if (last) begin
                busy_r <= 1'b0;
                rd_r <= s2_r;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end else if (cyc.req && !done_r) begin
                busy_r <= 1'b1;
                wr_r <= cyc.wr;
                fa_out <= cyc.addr;
                fdq_out <= cyc.wdata;
                cnt_r <= cyc.wr ? WCNT : RCNT + 4'h2;
            end
        end
    end
endmodule
`default_nettype wire

/* File: core/fcb_host.sv */
// Host controller issuing CRC check and unlock bypass sequences to a parallel flash
`timescale 1ns/100ps
`default_nettype none
module fcb_host (
    input  wire logic        mclk_in,       // System clock, 50 MHz
    input  wire logic        resetn_in,     // Synchronous reset, active low
    input  wire logic        ce_in,         // Clock enable
    input  wire logic        start_in,      // Start an operation pulse
    input  wire logic [1:0]  op_in,         // Operation, see fcb_op_t
    input  wire logic        byte_mode_in,  // One selects byte-wide bus
    input  wire logic [63:0] crc_exp_in,    // Expected CRC
    input  wire logic [31:0] start_addr_in, // Range start, byte address
    input  wire logic [31:0] stop_addr_in,  // Range stop, byte address
    output logic             busy_out,      // Operation in progress
    output logic             done_out,      // Operation finished pulse
    output logic             crc_fail_out,  // Last CRC check failed
    output logic             bypass_out,    // Bypass entered by command
    output logic [23:0]      fa_out,        // Flash address
    output logic [15:0]      fdq_out,       // Flash data out
    output logic             fdq_oe_out,    // Data drive enable
    input  wire logic [15:0] fdq_in,        // Flash data in
    output logic             fce_n_out,     // Chip enable, low active
    output logic             fwe_n_out,     // Write enable, low active
    output logic             foe_n_out,     // Output enable, low active
    output logic             hv_req_out     // High voltage request, always low
);
    typedef enum logic [2:0] {
        FCB_IDLE = 3'b000,
        FCB_WORD = 3'b001,  // Emit word of sequence
        FCB_LOB  = 3'b010,  // Byte mode low half
        FCB_HIB  = 3'b011,  // Byte mode high half
        FCB_POLL = 3'b100,  // Status read
        FCB_FIN  = 3'b101
    } fcb_st_t;

    fcb_cyc_if cyc ();
    fcb_st_t     st_r;         // Sequencer state
    logic [4:0]  idx_r;        // Step in sequence
    logic [1:0]  op_r;         // Latched operation
    logic        bm_r;         // Latched byte mode
    logic [15:0] prev_r;       // Previous poll read
    logic        pvld_r;       // Previous poll valid
    logic        fail_r;       // Failure flag
    logic        byp_r;        // Bypass mode state
    logic        issued_r;     // Cycle requested and pending
    logic [23:0] s_addr;       // Address of current step
    logic [15:0] s_data;       // Data of current step
    logic [4:0]  s_last;       // Last step index
    logic        s_bytes;      // Step split in byte mode
    logic        s_cmd;        // Step is command, unlock address
    logic [15:0] rd;           // Poll read data
    logic        toggling;     // Toggle bit still moving

    // Step table: one function decodes index to offset and data
    // CRC and address inputs are read live, not latched at start, so the
    // caller must hold them steady until done; this saves 128 flops
    function automatic logic [39:0] step(input logic [4:0] i, input logic [1:0] op,
                                         input logic bm);
        logic [15:0] d;
        logic [23:0] a;
        d = 16'h0000;
        a = 24'h000000;
        if (op == 2'(fcb_pkg::FCB_OP_BYP_EXIT)) begin
            d = (i == 5'h0) ? fcb_pkg::CMD_BYRST1 : fcb_pkg::CMD_BYRST2;
        end else begin
            unique case (i)
                5'h00: d = fcb_pkg::CMD_UNLK1;
                5'h01: d = fcb_pkg::CMD_UNLK2;
                5'h02: d = (op == 2'(fcb_pkg::FCB_OP_BYP_ENTER)) ? fcb_pkg::CMD_BYPASS
                                                                  : fcb_pkg::CMD_EXTFN;
                5'h03: d = fcb_pkg::CMD_CRC;
                5'h04: d = op[0] ? (bm ? fcb_pkg::CNT_RANGE_B : fcb_pkg::CNT_RANGE_W)
                                 : (bm ? fcb_pkg::CNT_CHIP_B : fcb_pkg::CNT_CHIP_W);
                5'h05: d = op[0] ? fcb_pkg::OPT_RANGE : fcb_pkg::OPT_CHIP;
                5'h06, 5'h07, 5'h08, 5'h09: begin
                    a = fcb_pkg::OFF_CRC0 + 24'(i - 5'h06);
                    d = crc_exp_in[16*(i-5'h06) +: 16];
                end
                5'h0A, 5'h0B: begin
                    a = fcb_pkg::OFF_START_L + 24'(i - 5'h0A);
                    d = start_addr_in[16*(i-5'h0A) +: 16];
                end
                5'h0C: a = fcb_pkg::OFF_RSVD1;
                5'h0D, 5'h0E: begin
                    a = fcb_pkg::OFF_STOP_L + 24'(i - 5'h0D);
                    d = stop_addr_in[16*(i-5'h0D) +: 16];
                end
                5'h0F: a = fcb_pkg::OFF_RSVD2;
                default: d = fcb_pkg::CMD_CONFIRM;
            endcase
        end
        return {a, d};
    endfunction

    // Range steps skipped for a chip check; confirm sits at index 16
    assign {s_addr, s_data} = step(idx_r, op_r, bm_r);
    assign s_last  = (op_r == 2'(fcb_pkg::FCB_OP_BYP_EXIT)) ? 5'h01 :
                     (op_r == 2'(fcb_pkg::FCB_OP_BYP_ENTER)) ? 5'h02 : 5'h10;
    assign s_bytes = bm_r && ((idx_r == 5'h05) || (idx_r >= 5'h06 && idx_r <= 5'h0F));
    assign s_cmd   = (idx_r <= 5'h01) && (op_r != 2'(fcb_pkg::FCB_OP_BYP_EXIT));
    assign rd      = cyc.rdata;
    assign toggling = pvld_r && (rd[fcb_pkg::TOGL_BIT] != prev_r[fcb_pkg::TOGL_BIT]);

    // Bus cycle request built from the current step
    // A split step issues no full-width write; only its two byte halves go out
    assign cyc.req = ((st_r == FCB_WORD && !s_bytes) || st_r == FCB_LOB || st_r == FCB_HIB ||
                      st_r == FCB_POLL) && !issued_r;
    assign cyc.wr  = (st_r != FCB_POLL);
    assign cyc.wdata = (st_r == FCB_HIB) ? {8'h00, s_data[15:8]} :
                       (st_r == FCB_LOB) ? {8'h00, s_data[7:0]} : s_data;
    assign cyc.addr = s_cmd ? (bm_r ? (idx_r[0] ? fcb_pkg::UNLK2_BADDR : fcb_pkg::UNLK1_BADDR)
                                    : (idx_r[0] ? fcb_pkg::UNLK2_WADDR : fcb_pkg::UNLK1_WADDR))
                    : (st_r == FCB_LOB) ? {s_addr[22:0], 1'b0} :
                      (st_r == FCB_HIB) ? {s_addr[22:0], 1'b1} : s_addr;

    assign busy_out     = (st_r != FCB_IDLE);
    assign crc_fail_out = fail_r;
    assign bypass_out   = byp_r;
    assign hv_req_out   = 1'b0;  // Bypass by command only, no high voltage

    fcb_cycle u_cyc (
        .mclk_in    (mclk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .cyc        (cyc.eng),
        .fa_out     (fa_out),
        .fdq_out    (fdq_out),
        .fdq_oe_out (fdq_oe_out),
        .fdq_in     (fdq_in),
        .fce_n_out  (fce_n_out),
        .fwe_n_out  (fwe_n_out),
        .foe_n_out  (foe_n_out)
    );

    // Sequencer: walk steps, split bytes, then poll for CRC ops
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            st_r <= FCB_IDLE;
            idx_r <= 5'h00;
            op_r <= 2'b00;
            bm_r <= 1'b0;
            prev_r <= 16'h0000;
            pvld_r <= 1'b0;
            fail_r <= 1'b0;
            byp_r <= 1'b0;
            issued_r <= 1'b0;
            done_out <= 1'b0;
        end else if (ce_in) begin
            done_out <= 1'b0;
            if (cyc.req)
                issued_r <= 1'b1;
            if (cyc.done)
                issued_r <= 1'b0;
            unique case (st_r)
                FCB_IDLE: if (start_in) begin
                    op_r <= op_in;
                    bm_r <= byte_mode_in;
                    idx_r <= 5'h00;
                    pvld_r <= 1'b0;
                    st_r <= FCB_WORD;
                end
                FCB_WORD, FCB_HIB: begin
                    if (st_r == FCB_WORD && s_bytes) begin
                        // Split step goes straight to its low byte, no wide write first
                        st_r <= FCB_LOB;
                    end else if (cyc.done) begin
                        if (idx_r == s_last)
                            st_r <= op_r[1] ? FCB_FIN : FCB_POLL;
                        else begin
                            // Chip check jumps from last CRC word to confirm
                            idx_r <= (!op_r[0] && idx_r == 5'h09) ? 5'h10 : idx_r + 5'h01;
                            st_r <= FCB_WORD;
                        end
                    end
                end
                FCB_LOB: if (cyc.done)
                    st_r <= FCB_HIB;
                // Two equal toggle reads mean the device is idle again
                FCB_POLL: if (cyc.done) begin
                    prev_r <= rd;
                    pvld_r <= 1'b1;
                    if (pvld_r && !toggling) begin
                        fail_r <= rd[fcb_pkg::FAIL_BIT];
                        st_r <= FCB_FIN;
                    end
                end
                FCB_FIN: begin
                    // Bypass flag follows the command just sent; CRC ops leave it
                    done_out <= 1'b1;
                    if (op_r == 2'(fcb_pkg::FCB_OP_BYP_ENTER))
                        byp_r <= 1'b1;
                    if (op_r == 2'(fcb_pkg::FCB_OP_BYP_EXIT))
                        byp_r <= 1'b0;
                    st_r <= FCB_IDLE;
                end
                default: st_r <= FCB_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: test/fcb_flash_model.sv */
// Behavioural flash device facing the command host
`timescale 1ns/100ps
`default_nettype none
module fcb_flash_model #(
    parameter logic [63:0] ARR_CRC = 64'h0123_4567_89AB_CDEF // Stand-in array CRC
) (
    input  wire logic        mclk_in,  // Samples strobes, address and write data
    input  wire logic        byte_in,  // Byte-wide bus
    input  wire logic        slow_in,  // Long busy spell
    input  wire logic        hv_in,    // High voltage on protect pin
    input  wire logic [23:0] fa_in,    // Address
    input  wire logic [15:0] fdq_in,   // Data from host
    input  wire logic        fce_n_in, // Chip enable
    input  wire logic        fwe_n_in, // Write strobe
    input  wire logic        foe_n_in, // Read strobe
    output logic      [15:0] fdq_out   // Data to host
);
    logic [23:0] wa[$];                // Logged write addresses
    logic [15:0] wd[$];                // Logged write data
    logic [15:0] mem[0:31];            // Sequence words by offset
    logic [23:0] pa;
    logic [15:0] pd, last = 16'h0000, rdv;
    logic [7:0]  prev = 8'h00;
    logic        in_wr = 1'h0, crc_arm = 1'h0, stat = 1'h0, fail = 1'h0;
    logic        byp_r = 1'h0, tog = 1'h0, mode;
    int          busy = 0;
    assign mode = byp_r | hv_in; // High voltage forces bypass
    // Status while polling, array data otherwise
    assign rdv = stat ? {9'h000, tog, fail & (busy == 0), 5'h00} : 16'h5A3C ^ fa_in[15:0];
    // Released bus shows the inverse, not a held value
    assign fdq_out = (!fce_n_in && !foe_n_in) ? rdv : ~last;
    function automatic logic [15:0] wv(input int k);
        return byte_in ? {mem[2 * k + 1][7:0], mem[2 * k][7:0]} : mem[k];
    endfunction
    // Check ends: CRC stand-in compared with expected
    task automatic crc_fin();
        logic [31:0] s, t;
        s = {wv(6), wv(5)}; // Byte addresses in both modes
        t = {wv(9), wv(8)};
        crc_arm = 1'h0;
        stat = 1'h1;
        busy = slow_in ? 6 : 1;
        if (wv(0) == 16'hFFFE && t <= s) fail = 1'h0; // No computation
        else fail = ({wv(4), wv(3), wv(2), wv(1)} != ARR_CRC);
    endtask
    task automatic wr_cmd(input logic [23:0] a, input logic [15:0] d);
        wa.push_back(a);
        wd.push_back(d);
        stat = 1'h0;
        // Confirm also lands on offset zero; keep the option word for the range test
        if (a < 24'h20 && !(crc_arm && a == 24'h0 && d[7:0] == 8'h29)) mem[a[4:0]] = d;
        // Exit taken with no unlock prefix while in bypass
        if (mode && prev == 8'h90 && d[7:0] == 8'h00) byp_r = 1'h0;
        else if (!crc_arm && prev == 8'h55 && d[7:0] == 8'h20) byp_r = 1'h1;
        else if (!mode && prev == 8'hEB && d[7:0] == 8'h27) crc_arm = 1'h1;
        else if (crc_arm && a == 24'h0 && d[7:0] == 8'h29) crc_fin();
        prev = d[7:0];
    endtask
    // Latch a write while strobed, act once it ends
    always @(posedge mclk_in) begin
        if (!fce_n_in && !fwe_n_in) begin
            pa = fa_in;
            pd = fdq_in;
            in_wr = 1'h1;
        end else if (in_wr) begin
            in_wr = 1'h0;
            wr_cmd(pa, pd);
        end
    end
    // Busy bit toggles once per status read while busy count remains
    always @(posedge foe_n_in) begin
        last = rdv;
        if (stat && busy > 0) begin
            tog = ~tog;
            busy--;
        end
    end
endmodule
`default_nettype wire

/* File: test/fcb_host_checker.sv */
// Port checker for the flash command host
`timescale 1ns/100ps
`default_nettype none
module fcb_chk (
    input wire logic        mclk_in,    // Clock
    input wire logic        resetn_in,  // Reset, low active
    input wire logic        start_in,   // Start pulse
    input wire logic        busy_out,   // Busy
    input wire logic        done_out,   // Done pulse
    input wire logic [23:0] fa_out,     // Address
    input wire logic        fdq_oe_out, // Drive enable
    input wire logic        fce_n_out,  // Chip enable
    input wire logic        fwe_n_out,  // Write strobe
    input wire logic        foe_n_out,  // Read strobe
    input wire logic        hv_req_out  // High voltage request
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // Strobes exclusive so pins never fight
    we_oe_excl_a: assert property (fwe_n_out || foe_n_out)
        else $error("strobes overlap");
    wr_drive_a: assert property (!fwe_n_out |-> fdq_oe_out && !fce_n_out)
        else $error("write not driven");
    rd_release_a: assert property (!foe_n_out |-> !fdq_oe_out && !fce_n_out)
        else $error("read while driving");
    // Strobe and address must hold for the two cycles after the strobe falls
    wr_hold_a: assert property ($fell(fwe_n_out) |=> (!fwe_n_out && $stable(fa_out)) [*2])
        else $error("write strobe short");
    hv_off_a: assert property (!hv_req_out)
        else $error("high voltage asked");
    idle_bus_a: assert property (!busy_out |-> fce_n_out && !fdq_oe_out)
        else $error("bus active in idle");
    done_once_a: assert property (done_out |-> $past(busy_out) ##1 !done_out)
        else $error("bad done pulse");
    start_busy_a: assert property (start_in && !busy_out |=> busy_out)
        else $error("start not taken");
    busy_min_a: assert property ($rose(busy_out) |-> busy_out [*8])
        else $error("busy too short");
endmodule
bind fcb_host fcb_chk chk_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .start_in(start_in),
    .busy_out(busy_out), .done_out(done_out), .fa_out(fa_out), .fdq_oe_out(fdq_oe_out),
    .fce_n_out(fce_n_out), .fwe_n_out(fwe_n_out), .foe_n_out(foe_n_out),
    .hv_req_out(hv_req_out));
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the flash command host
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [63:0] GOOD = 64'h0123_4567_89AB_CDEF; // Model's array CRC
    logic        clk = 1'h0, rst_n = 1'h0, start = 1'h0, bm = 1'h0, slow = 1'h0;
    logic [1:0]  op = 2'h0;
    logic [63:0] crc = 64'h0;
    logic [31:0] sa = 32'h0, ta = 32'h0;
    logic        busy, done, fail, byp, oe, ce_n, we_n, oe_n, hv;
    logic [23:0] fa, ea[$];
    logic [15:0] h_dq, f_dq, dq, ed[$];
    int          err_total = 0, check_count = 0;
    assign dq = oe ? h_dq : f_dq; // Wire level from both drivers
    fcb_host dut (.mclk_in(clk), .resetn_in(rst_n), .ce_in(1'h1), .start_in(start),
        .op_in(op), .byte_mode_in(bm), .crc_exp_in(crc), .start_addr_in(sa),
        .stop_addr_in(ta), .busy_out(busy), .done_out(done), .crc_fail_out(fail),
        .bypass_out(byp), .fa_out(fa), .fdq_out(h_dq), .fdq_oe_out(oe), .fdq_in(dq),
        .fce_n_out(ce_n), .fwe_n_out(we_n), .foe_n_out(oe_n), .hv_req_out(hv));
    fcb_flash_model #(.ARR_CRC(GOOD)) flash (.mclk_in(clk), .byte_in(bm), .slow_in(slow),
        .hv_in(hv), .fa_in(fa), .fdq_in(dq), .fce_n_in(ce_n), .fwe_n_in(we_n),
        .foe_n_in(oe_n), .fdq_out(f_dq));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic ex(input logic [23:0] a, input logic [15:0] d);
        ea.push_back(a);
        ed.push_back(d);
    endtask
    // Start an op, poke a second start mid-run, wait for done
    task automatic run(input logic [1:0] o);
        int n;
        flash.wa.delete();
        flash.wd.delete();
        @(negedge clk);
        op = o;
        start = 1'h1;
        n = 0;
        while (done !== 1'h1 && n < 3000) begin
            @(negedge clk);
            start = (n == 12);
            op = ~o;
            n++;
        end
        chk(n < 3000, 1'h1);
    endtask
    // Logged writes against expected list; 24'hFFFFFF skips address
    task automatic cmp_seq();
        logic [15:0] m;
        m = bm ? 16'h00FF : 16'hFFFF;
        chk(flash.wa.size(), ea.size());
        if (flash.wa.size() == ea.size()) begin
            foreach (ea[i]) begin
                if (ea[i] !== 24'hFFFFFF) chk(flash.wa[i], ea[i]);
                chk(flash.wd[i] & m, ed[i] & m);
            end
        end
    endtask
    task automatic unl();
        ea.delete();
        ed.delete();
        ex(bm ? fcb_pkg::UNLK1_BADDR : fcb_pkg::UNLK1_WADDR, fcb_pkg::CMD_UNLK1);
        ex(bm ? fcb_pkg::UNLK2_BADDR : fcb_pkg::UNLK2_WADDR, fcb_pkg::CMD_UNLK2);
    endtask
    // Build a CRC sequence, run it, judge writes and fail flag
    task automatic crc_op(input logic [1:0] o, input logic f);
        logic [15:0] w[0:10];
        int n;
        n = o[0] ? 10 : 4;
        w = '{o[0] ? 16'hFFFE : 16'hFFFF, crc[15:0], crc[31:16], crc[47:32], crc[63:48],
              sa[15:0], sa[31:16], 16'h0000, ta[15:0], ta[31:16], 16'h0000};
        unl();
        ex(24'h0, 16'h00EB);
        ex(24'h0, 16'h0027);
        ex(24'h0, bm ? 16'(2 * n + 1) : 16'(n));
        for (int k = 0; k <= n; k++) begin
            if (bm) begin
                ex(24'(2 * k), w[k] & 16'h00FF);
                ex(24'(2 * k + 1), w[k] >> 8);
            end else begin
                ex(24'(k), w[k]);
            end
        end
        ex(24'h0, 16'h0029);
        run(o);
        cmp_seq();
        chk(fail, f);
    endtask
    task automatic sc_chip_word();
        crc = GOOD;
        crc_op(fcb_pkg::FCB_OP_CRC_CHIP, 1'h0);
    endtask
    // Byte bus, slow device, wrong CRC
    task automatic sc_chip_byte();
        bm = 1'h1;
        slow = 1'h1;
        crc = ~GOOD;
        crc_op(fcb_pkg::FCB_OP_CRC_CHIP, 1'h1);
    endtask
    task automatic sc_range_word();
        bm = 1'h0;
        sa = 32'h0001_2345;
        ta = 32'h00AB_CDEF;
        crc = GOOD ^ 64'h1;
        crc_op(fcb_pkg::FCB_OP_CRC_RANGE, 1'h1);
    endtask
    // Stop equal to start: nothing computed
    task automatic sc_range_empty();
        sa = ta;
        crc_op(fcb_pkg::FCB_OP_CRC_RANGE, 1'h0);
    endtask
    task automatic sc_range_byte();
        bm = 1'h1;
        slow = 1'h0;
        sa = 32'h0000_0101;
        crc = GOOD;
        crc_op(fcb_pkg::FCB_OP_CRC_RANGE, 1'h0);
    endtask
    // Bypass entry then exit by command
    task automatic sc_bypass();
        unl();
        ex(24'hFFFFFF, 16'h0020);
        run(fcb_pkg::FCB_OP_BYP_ENTER);
        cmp_seq();
        chk({byp, flash.byp_r}, 2'h3);
        ea.delete();
        ed.delete();
        ex(24'h0, 16'h0090);
        ex(24'h0, 16'h0000);
        run(fcb_pkg::FCB_OP_BYP_EXIT);
        cmp_seq();
        chk({byp, flash.byp_r}, 2'h0);
    endtask
    initial begin
        repeat (4) @(negedge clk);
        chk({busy, byp, done}, 3'h0);
        rst_n = 1'h1;
        sc_chip_word();
        sc_chip_byte();
        sc_range_word();
        sc_range_empty();
        sc_range_byte();
        sc_bypass();
        results();
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        results();
    end
endmodule
`default_nettype wire
